// *** flash_cmd_pkg.sv ***
`default_nettype none
package flash_cmd_pkg;

   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] normal_read_cmd                  = 8'h03;
   localparam logic [7:0] normal_read_wide_addr_cmd        = 8'h13;
   localparam logic [7:0] bank_reg_read_cmd                = 8'h16;
   localparam logic [7:0] bank_reg_read_alt_cmd            = 8'hC8;
   localparam logic [7:0] bank_reg_volatile_write_cmd      = 8'h17;
   localparam logic [7:0] bank_reg_volatile_write_alt_cmd  = 8'hC5;
   localparam logic [7:0] bank_reg_persistent_write_cmd    = 8'h18;
   localparam logic [7:0] wide_addr_enter_cmd              = 8'hB7;
   localparam logic [7:0] wide_addr_exit_cmd               = 8'h29;
   localparam logic [7:0] volatile_lock_read_cmd           = 8'hFA;
   localparam logic [7:0] volatile_lock_read_wide_cmd      = 8'hE0;
   localparam logic [7:0] volatile_lock_write_cmd          = 8'hFB;
   localparam logic [7:0] volatile_lock_write_wide_cmd     = 8'hE1;
   localparam logic [7:0] persistent_lock_read_cmd         = 8'hFC;
   localparam logic [7:0] persistent_lock_read_wide_cmd    = 8'hE2;
   localparam logic [7:0] persistent_lock_program_cmd      = 8'hFD;
   localparam logic [7:0] persistent_lock_program_wide_cmd = 8'hE3;
   localparam logic [7:0] persistent_lock_erase_all_cmd    = 8'hE4;
   localparam logic [7:0] lock_guard_read_cmd              = 8'hA7;
   localparam logic [7:0] lock_guard_set_cmd               = 8'hA6;
   localparam logic [7:0] gang_lock_cmd                    = 8'h7E;
   localparam logic [7:0] gang_unlock_cmd                  = 8'h98;
   localparam logic [7:0] training_pattern_read_cmd        = 8'h41;
   localparam logic [7:0] training_pattern_persistent_cmd  = 8'h43;
   localparam logic [7:0] training_pattern_volatile_cmd    = 8'h4A;

   // ---------------------------------------------------------------
   // Register map and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS  = 8'h04;
   localparam logic [7:0] BANK_OFS    = 8'h08;
   localparam logic [7:0] TRAIN_OFS   = 8'h0C;
   localparam logic [7:0] RDADDR_OFS  = 8'h10;
   localparam int         CTRL_BUSY_BIT = 0;
   localparam int         CTRL_QPI_BIT  = 1;
   localparam logic [7:0] BANK_RST    = 8'h00;
   localparam logic [7:0] TRAIN_RST   = 8'h00;
   localparam logic [1:0] CTRL_RST    = 2'h0;
   localparam logic [2:0] SYNC_IDLE   = 3'h4;   // cs_n high, sck low, si low

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DIN, ST_DOUT, ST_IGNORE} spi_state_e;

   typedef struct packed {
      logic known;
      logic has_addr;
      logic addr4;
      logic rd;
      logic wr;
      logic mem;
   } cmd_attr_s;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } ahb_ap_s;

   function automatic cmd_attr_s cmd_decode(input logic [7:0] op, input logic wide);
      cmd_attr_s a;
      a = '0;
      a.known = 1'b1;
      case (op)
         normal_read_cmd, volatile_lock_read_cmd, persistent_lock_read_cmd: begin
            a.has_addr = 1'b1;
            a.addr4    = wide;
            a.rd       = 1'b1;
            a.mem      = (op == normal_read_cmd);
         end
         normal_read_wide_addr_cmd, volatile_lock_read_wide_cmd, persistent_lock_read_wide_cmd: begin
            a.has_addr = 1'b1;
            a.addr4    = 1'b1;
            a.rd       = 1'b1;
            a.mem      = (op == normal_read_wide_addr_cmd);
         end
         volatile_lock_write_cmd, persistent_lock_program_cmd: begin
            a.has_addr = 1'b1;
            a.addr4    = wide;
            a.wr       = (op == volatile_lock_write_cmd);
         end
         volatile_lock_write_wide_cmd, persistent_lock_program_wide_cmd: begin
            a.has_addr = 1'b1;
            a.addr4    = 1'b1;
            a.wr       = (op == volatile_lock_write_wide_cmd);
         end
         bank_reg_read_cmd, bank_reg_read_alt_cmd, lock_guard_read_cmd, training_pattern_read_cmd: begin
            a.rd = 1'b1;
         end
         bank_reg_volatile_write_cmd, bank_reg_volatile_write_alt_cmd, bank_reg_persistent_write_cmd,
         training_pattern_persistent_cmd, training_pattern_volatile_cmd: begin
            a.wr = 1'b1;
         end
         wide_addr_enter_cmd, wide_addr_exit_cmd, persistent_lock_erase_all_cmd,
         lock_guard_set_cmd, gang_lock_cmd, gang_unlock_cmd: begin
            a.known = 1'b1;
         end
         default: begin
            a.known = 1'b0;
         end
      endcase
      return a;
   endfunction

endpackage
`default_nettype wire

// *** flash_cmd_top.sv ***
// Summary of operation
// (R1) 03h address width follows mode; 13h four-byte
// (R2) Shift all address bits, decode valid ones
// (R3) Wide mode uses A25-A0, else A23-A0
// (R4) Data MSB first, address increments per byte
// (R5) Read address wraps to zero past top
// (R6) Host ends read by raising chip select
// (R7) Read ignored while write in progress
// (R8) Input ignored after address is received
// (R9) 16h/C8h return volatile bank register
// (R10) 17h/C5h load volatile bank register
// (R11) 18h writes persistent bank register copy
// (R12) B7h enters four-byte address mode
// (R13) 29h returns to three-byte address mode
// (R14) FAh/E0h read sector volatile lock bit
// (R15) FBh/E1h write sector volatile lock bit
// (R16) FCh/E2h read persistent bit, single-line only
// (R17) FDh/E3h program persistent bit unless lock guard set, no data
// (R18) E4h erases all persistent lock bits unless lock guard set
// (R19) A7h reads lock guard; A6h sets it
// (R20) 7Eh sets all volatile lock bits
// (R21) 98h clears all volatile lock bits
// (R22) 41h/43h/4Ah training pattern read and writes
// (R23) Opcode, address MSB first on rising clock
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_top
   import flash_cmd_pkg::*;
#(
   parameter int ADDR_BITS = 26,
   parameter int SECT_BITS = 10
) (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic                 hready,
   input  wire logic [31:0]          hwdata,
   output var  logic [31:0]          hrdata,
   output var  logic                 hreadyout,
   output var  logic                 hresp,
   input  wire logic                 cs_n,
   input  wire logic                 sck,
   input  wire logic                 si,
   output var  logic                 so_o,
   output var  logic                 so_oe,
   output var  logic [ADDR_BITS-1:0] mem_addr,
   input  wire logic [7:0]           mem_rdata
);

   localparam int SECTORS  = 2 ** SECT_BITS;
   localparam int SECT_LSB = ADDR_BITS - SECT_BITS;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;
   logic [2:0] pin_r;
   logic [2:0] pin_nxt;
   logic       cs_hi;
   logic       sck_rise;
   logic       sck_fall;
   logic       si_f;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= SYNC_IDLE;
         sync2_r <= SYNC_IDLE;
         sync3_r <= SYNC_IDLE;
         pin_r   <= SYNC_IDLE;
      end else begin
         sync1_r <= {cs_n, sck, si};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         pin_r   <= pin_nxt;
      end
   end

   // A change counts once stages two and three agree
   assign pin_nxt  = (sync2_r & ~(sync2_r ^ sync3_r)) | (pin_r & (sync2_r ^ sync3_r));
   assign cs_hi    = pin_nxt[2];
   // (R23) rising edge samples
   assign sck_rise = ~pin_r[1] & pin_nxt[1] & ~cs_hi;
   assign sck_fall = pin_r[1] & ~pin_nxt[1] & ~cs_hi;
   assign si_f     = pin_r[0];

   // ---------------------------------------------------------------
   // Control register and busy flag
   // ---------------------------------------------------------------
   ahb_ap_s    ap_r;
   logic [1:0] ctrl_r;
   logic [1:0] ctrl_nxt;
   logic       write_in_progress_flag;
   logic       qpi_mode;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (ap_r.valid && ap_r.write && ap_r.addr == CTRL_OFS) begin
         ctrl_nxt = hwdata[1:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign write_in_progress_flag = ctrl_r[CTRL_BUSY_BIT];
   assign qpi_mode               = ctrl_r[CTRL_QPI_BIT];

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   spi_state_e  state_r;
   cmd_attr_s   attr_r;
   cmd_attr_s   attr_in;
   logic [7:0]  opcode_r;
   logic [7:0]  rx_r;
   logic [7:0]  rx_byte;
   logic [2:0]  bit_cnt_r;
   logic [1:0]  byte_cnt_r;
   logic [31:0] addr_r;
   logic        op_done_r;
   logic        addr_done_r;
   logic        din_done_r;
   logic        hdr_done_r;
   logic        wide_address_select;
   logic        refuse;

   assign rx_byte = {rx_r[6:0], si_f};
   assign attr_in = cmd_decode(rx_byte, wide_address_select);
   // (R7) busy refuses reads
   assign refuse  = !attr_in.known || (attr_in.rd && write_in_progress_flag) ||
                    // (R16) single-line only
                    (qpi_mode && (rx_byte == persistent_lock_read_cmd ||
                                  rx_byte == persistent_lock_read_wide_cmd));

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r     <= ST_OPCODE;
         attr_r      <= '0;
         opcode_r    <= 8'h00;
         rx_r        <= 8'h00;
         bit_cnt_r   <= 3'h0;
         byte_cnt_r  <= 2'h0;
         addr_r      <= 32'h0000_0000;
         op_done_r   <= 1'b0;
         addr_done_r <= 1'b0;
         din_done_r  <= 1'b0;
         hdr_done_r  <= 1'b0;
      end else begin
         op_done_r   <= 1'b0;
         addr_done_r <= 1'b0;
         din_done_r  <= 1'b0;
         hdr_done_r  <= 1'b0;
         if (cs_hi) begin
            state_r   <= ST_OPCODE;
            bit_cnt_r <= 3'h0;
         end else if (sck_rise) begin
            rx_r      <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            case (state_r)
               ST_OPCODE: begin
                  if (bit_cnt_r == 3'h7) begin
                     opcode_r <= rx_byte;
                     attr_r   <= attr_in;
                     addr_r   <= 32'h0000_0000;
                     // (R1) address length select
                     byte_cnt_r <= attr_in.addr4 ? 2'h3 : 2'h2;
                     if (refuse) begin
                        state_r <= ST_IGNORE;
                     end else if (attr_in.has_addr) begin
                        state_r <= ST_ADDR;
                     end else if (attr_in.rd) begin
                        state_r    <= ST_DOUT;
                        hdr_done_r <= 1'b1;
                     end else if (attr_in.wr) begin
                        state_r <= ST_DIN;
                     end else begin
                        state_r   <= ST_IGNORE;
                        op_done_r <= 1'b1;
                     end
                  end
               end
               ST_ADDR: begin
                  // (R2) all bits shifted in
                  addr_r <= {addr_r[30:0], si_f};
                  if (bit_cnt_r == 3'h7) begin
                     byte_cnt_r <= byte_cnt_r - 2'h1;
                     if (byte_cnt_r == 2'h0) begin
                        addr_done_r <= 1'b1;
                        if (attr_r.rd) begin
                           state_r    <= ST_DOUT;
                           hdr_done_r <= 1'b1;
                        end else if (attr_r.wr) begin
                           state_r <= ST_DIN;
                        end else begin
                           state_r <= ST_IGNORE;
                        end
                     end
                  end
               end
               ST_DIN: begin
                  if (bit_cnt_r == 3'h7) begin
                     din_done_r <= 1'b1;
                     state_r    <= ST_IGNORE;
                  end
               end
               // (R8) input ignored afterwards
               ST_DOUT, ST_IGNORE: begin
                  state_r <= state_r;
               end
               default: begin
                  state_r <= ST_IGNORE;
               end
            endcase
         end
      end
   end

   // (R3) valid address bits
   logic [ADDR_BITS-1:0] eff_addr;
   logic [SECT_BITS-1:0] sect;
   assign eff_addr = attr_r.addr4 ? addr_r[ADDR_BITS-1:0] : ADDR_BITS'(addr_r[23:0]);
   assign sect     = eff_addr[ADDR_BITS-1:SECT_LSB];

   // ---------------------------------------------------------------
   // Device registers and lock bits
   // ---------------------------------------------------------------
   logic [7:0]         bank_v_r;
   logic [7:0]         bank_nv_r;
   logic [7:0]         train_v_r;
   logic [7:0]         train_nv_r;
   logic [SECTORS-1:0] lock_v_r;
   logic [SECTORS-1:0] lock_p_r;
   logic               guard_r;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wide_address_select <= 1'b0;
         guard_r             <= 1'b0;
         lock_v_r            <= '0;
         lock_p_r            <= '0;
      end else if (op_done_r) begin
         case (opcode_r)
            // (R12) enter wide mode
            wide_addr_enter_cmd:           wide_address_select <= 1'b1;
            // (R13) leave wide mode
            wide_addr_exit_cmd:            wide_address_select <= 1'b0;
            // (R18) group erase
            persistent_lock_erase_all_cmd: if (!guard_r) lock_p_r <= '0;
            // (R19) set lock guard
            lock_guard_set_cmd:            guard_r <= 1'b1;
            // (R20) gang lock
            gang_lock_cmd:                 lock_v_r <= '1;
            // (R21) gang unlock
            gang_unlock_cmd:               lock_v_r <= '0;
            default:                       guard_r <= guard_r;
         endcase
      end else if (addr_done_r && !guard_r && (opcode_r == persistent_lock_program_cmd ||
                                              opcode_r == persistent_lock_program_wide_cmd)) begin
         // (R17) program one sector
         lock_p_r[sect] <= 1'b1;
      end else if (din_done_r && (opcode_r == volatile_lock_write_cmd ||
                                  opcode_r == volatile_lock_write_wide_cmd)) begin
         // (R15) write volatile lock
         lock_v_r[sect] <= rx_r[0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bank_v_r   <= BANK_RST;
         bank_nv_r  <= BANK_RST;
         train_v_r  <= TRAIN_RST;
         train_nv_r <= TRAIN_RST;
      end else if (din_done_r) begin
         case (opcode_r)
            // (R10) volatile bank load
            bank_reg_volatile_write_cmd, bank_reg_volatile_write_alt_cmd: bank_v_r <= rx_r;
            // (R11) persistent bank copy
            bank_reg_persistent_write_cmd:   bank_nv_r  <= rx_r;
            // (R22) training pattern writes
            training_pattern_persistent_cmd: train_nv_r <= rx_r;
            training_pattern_volatile_cmd:   train_v_r  <= rx_r;
            default:                         bank_v_r   <= bank_v_r;
         endcase
      end
   end

   // Byte answered by register read commands
   logic [7:0] reg_byte;
   always_comb begin
      case (opcode_r)
         // (R9) bank register out
         bank_reg_read_cmd, bank_reg_read_alt_cmd: reg_byte = bank_v_r;
         // (R14) volatile lock out
         volatile_lock_read_cmd, volatile_lock_read_wide_cmd: reg_byte = {8{lock_v_r[sect]}};
         // (R16) persistent lock out
         persistent_lock_read_cmd, persistent_lock_read_wide_cmd: reg_byte = {8{lock_p_r[sect]}};
         // (R19) guard bit out
         lock_guard_read_cmd:       reg_byte = {7'h00, guard_r};
         // (R22) training pattern out
         training_pattern_read_cmd: reg_byte = train_v_r;
         default:                   reg_byte = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Serial output path
   // ---------------------------------------------------------------
   logic [7:0] tx_sr_r;
   logic [2:0] tx_cnt_r;
   logic [1:0] fetch_r;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mem_addr <= '0;
         tx_sr_r  <= 8'h00;
         tx_cnt_r <= 3'h0;
         fetch_r  <= 2'h0;
         so_o     <= 1'b0;
         so_oe    <= 1'b0;
      end else begin
         fetch_r <= {fetch_r[0], 1'b0};
         if (fetch_r[1]) begin
            tx_sr_r <= mem_rdata;
         end
         if (cs_hi) begin
            // (R6) stop driving on deselect
            so_oe    <= 1'b0;
            tx_cnt_r <= 3'h0;
         end else if (hdr_done_r) begin
            tx_cnt_r <= 3'h0;
            if (attr_r.mem) begin
               mem_addr   <= eff_addr;
               fetch_r[0] <= 1'b1;
            end else begin
               tx_sr_r <= reg_byte;
            end
         end else if (sck_fall && state_r == ST_DOUT) begin
            // (R4) MSB first shift
            so_o     <= tx_sr_r[7];
            so_oe    <= 1'b1;
            tx_sr_r  <= {tx_sr_r[6:0], 1'b0};
            tx_cnt_r <= tx_cnt_r + 3'h1;
            if (tx_cnt_r == 3'h7) begin
               if (attr_r.mem) begin
                  // (R5) counter wraps at top
                  mem_addr   <= mem_addr + ADDR_BITS'(1);
                  fetch_r[0] <= 1'b1;
               end else begin
                  tx_sr_r <= reg_byte;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      case (haddr[7:0])
         CTRL_OFS:   rd_mux = {30'h0, ctrl_nxt};
         STATUS_OFS: rd_mux = {29'h0, so_oe, guard_r, wide_address_select};
         BANK_OFS:   rd_mux = {16'h0, bank_nv_r, bank_v_r};
         TRAIN_OFS:  rd_mux = {16'h0, train_nv_r, train_v_r};
         RDADDR_OFS: rd_mux = 32'(mem_addr);
         default:    rd_mux = 32'h0000_0000;
      endcase
      if (haddr[31:8] != 24'h00_0000) begin
         rd_mux = 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ap_r   <= '0;
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         ap_r.valid <= hsel && htrans[1] && (haddr[31:8] == 24'h00_0000);
         ap_r.write <= hwrite;
         ap_r.addr  <= haddr[7:0];
         if (hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

endmodule // flash_cmd_top
`default_nettype wire

// *** flash_cmd_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_assertions
   import flash_cmd_pkg::*;
#(
   parameter int ADDR_BITS = 26
) (
   input wire logic                 mclk,
   input wire logic                 reset_n,
   input wire logic                 hsel,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic                 hready,
   input wire logic [31:0]          hrdata,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic                 cs_n,
   input wire logic                 sck,
   input wire logic                 so_o,
   input wire logic                 so_oe,
   input wire logic [ADDR_BITS-1:0] mem_addr
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_oe_drop; cs_n [*8] |-> !so_oe; endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("so_oe on while deselected");
   property p_oe_rise; $rose(so_oe) |-> !cs_n && !sck; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("so_oe rose outside low clock");
   property p_oe_keep; so_oe && !cs_n |=> so_oe; endproperty
   a_oe_keep: assert property (p_oe_keep) else $error("so_oe dropped inside frame");
   property p_so_hold; so_oe && sck |-> $stable(so_o); endproperty
   a_so_hold: assert property (p_so_hold) else $error("so_o moved while clock high");
   property p_addr_step; so_oe && $changed(mem_addr) |-> mem_addr == $past(mem_addr) + ADDR_BITS'(1); endproperty
   a_addr_step: assert property (p_addr_step) else $error("read address not stepped by one");
   property p_addr_quiet; cs_n [*8] |-> $stable(mem_addr); endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("read address moved while idle");
   property p_ready; hreadyout && !hresp; endproperty
   a_ready: assert property (p_ready) else $error("bus not ready or not okay");
   property p_rd_hold; $changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
   c_read: cover property ($rose(so_oe));
   c_wrap: cover property (so_oe && $changed(mem_addr) && mem_addr == '0);
   c_bus: cover property ($changed(hrdata));
endmodule // flash_cmd_assertions
bind flash_cmd_top flash_cmd_assertions #(.ADDR_BITS(ADDR_BITS)) u_chk (.mclk, .reset_n, .hsel, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .cs_n, .sck, .so_o, .so_oe, .mem_addr);
`default_nettype wire

// *** spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic mclk,
   input  wire logic so_o,
   input  wire logic so_oe,
   output var  logic cs_n,
   output var  logic sck,
   output var  logic si
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   task automatic xfer(input logic [63:0] tx, input int nt, input int nr, output logic [63:0] rx,
                       output logic oe);
      int i;
      rx = '0;
      oe = 1'b0;
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (i = 0; i < nt + nr; i++) begin
         si <= (i < nt) ? tx[nt-1-i] : ~si;
         repeat (10) @(posedge mclk);
         sck <= 1'b1;
         if (i >= nt) begin
            // Released line reads as the inverse of its last level
            rx = {rx[62:0], so_oe ? so_o : ~so_o};
            oe |= so_oe;
         end
         repeat (10) @(posedge mclk);
         sck <= 1'b0;
      end
      repeat (6) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge mclk);
   endtask
endmodule // spi_host_model
`default_nettype wire

// *** serial_flash_read_and_protect_cmds_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_and_protect_cmds_tb_top;
   typedef struct packed {logic [47:0] tx; int nt; int nr; logic [15:0] ex; logic oe;} row_s;
   logic        mclk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, cs_n, sck, si, so_o, so_oe;
   logic [25:0] mem_addr;
   logic [7:0]  mem_rdata;
   int          fails = 0, tests_run = 0;
   row_s rows [32] = '{
      '{48'h16, 8, 8, 16'h0, 1'b1}, '{48'h17A5, 16, 0, 16'h0, 1'b0},
      '{48'hC8, 8, 8, 16'hA5, 1'b1}, '{48'hC53C, 16, 0, 16'h0, 1'b0},
      '{48'h185A, 16, 0, 16'h0, 1'b0}, '{48'h4A96, 16, 0, 16'h0, 1'b0},
      '{48'h41, 8, 8, 16'h96, 1'b1}, '{48'h4369, 16, 0, 16'h0, 1'b0},
      '{48'hFB01000001, 40, 0, 16'h0, 1'b0}, '{48'hFA010000, 32, 8, 16'hFF, 1'b1},
      '{48'h7E, 8, 0, 16'h0, 1'b0}, '{48'hE000050000, 40, 8, 16'hFF, 1'b1},
      '{48'h98, 8, 0, 16'h0, 1'b0}, '{48'hFA010000, 32, 8, 16'h0, 1'b1},
      '{48'hE10003000001, 48, 0, 16'h0, 1'b0}, '{48'hE000030000, 40, 8, 16'hFF, 1'b1},
      '{48'hFD040000, 32, 0, 16'h0, 1'b0}, '{48'hFC040000, 32, 8, 16'hFF, 1'b1},
      '{48'hE4, 8, 0, 16'h0, 1'b0}, '{48'hE200040000, 40, 8, 16'h0, 1'b1},
      '{48'h03123456, 32, 16, 16'h4445, 1'b1}, '{48'hB7, 8, 0, 16'h0, 1'b0},
      '{48'h03FEFFFFFF, 40, 16, 16'h0203, 1'b1}, '{48'h03FFFFFFFF, 40, 16, 16'h0300, 1'b1},
      '{48'hFDFF070000, 40, 0, 16'h0, 1'b0}, '{48'h29, 8, 0, 16'h0, 1'b0},
      '{48'h13FC000010, 40, 16, 16'h1011, 1'b1}, '{48'h03FF0001, 32, 16, 16'hFEFD, 1'b1},
      '{48'hA6, 8, 0, 16'h0, 1'b0}, '{48'hE4, 8, 0, 16'h0, 1'b0},
      '{48'hE203070000, 40, 8, 16'hFF, 1'b1}, '{48'hA7, 8, 8, 16'h1, 1'b1}};
   always #12.5 mclk = ~mclk;
   assign hready = hreadyout;
   assign mem_rdata = mem_addr[7:0] ^ mem_addr[23:16] ^ {6'h0, mem_addr[25:24]};
   flash_cmd_top dut (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
      .hrdata, .hreadyout, .hresp, .cs_n, .sck, .si, .so_o, .so_oe, .mem_addr, .mem_rdata);
   spi_host_model host (.mclk, .so_o, .so_oe, .cs_n, .sck, .si);
   // ---------------------------------------------------------------
   // Bus and frame helpers
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic run(input logic [47:0] t, input int nt, input int nr, input logic [15:0] e, input logic eo);
      logic [63:0] rx;
      logic        oe;
      host.xfer({16'h0, t}, nt, nr, rx, oe);
      chk("so_oe", eo, oe);
      if (eo) chk("spi_data", e, rx[15:0]);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge mclk);
      fails++;
      end_of_test;
   end
   initial begin
      logic [31:0] v;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (8) @(posedge mclk);
      foreach (rows[i]) run(rows[i].tx, rows[i].nt, rows[i].nr, rows[i].ex, rows[i].oe);
      ahb(32'h8, 1'b0, 32'h0, v); chk("bank", 32'h5A3C, v);
      ahb(32'hC, 1'b0, 32'h0, v); chk("train", 32'h6996, v);
      ahb(32'h4, 1'b0, 32'h0, v); chk("status", 32'h2, v);
      ahb(32'h40, 1'b0, 32'h0, v); chk("unmapped", 32'h0, v);
      ahb(32'h0, 1'b1, 32'h1, v); ahb(32'h0, 1'b0, 32'h0, v); chk("ctrl", 32'h1, v);
      run(48'h03123456, 32, 16, 16'h0, 1'b0);
      ahb(32'h10, 1'b0, 32'h0, v); chk("rdaddr", 32'h00FF_0003, v);
      ahb(32'h0, 1'b1, 32'h2, v);
      run(48'hFC040000, 32, 8, 16'h0, 1'b0);
      run(48'hFA010000, 32, 8, 16'h0, 1'b1);
      ahb(32'h0, 1'b1, 32'h0, v);
      @(posedge mclk) reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      ahb(32'h8, 1'b0, 32'h0, v); chk("bank_reset", 32'h0, v);
      ahb(32'h4, 1'b0, 32'h0, v); chk("status_reset", 32'h0, v);
      run(48'hE300090000, 40, 0, 16'h0, 1'b0);
      run(48'hE200090000, 40, 8, 16'hFF, 1'b1);
      end_of_test;
   end
endmodule // serial_flash_read_and_protect_cmds_tb_top
`default_nettype wire
